// File: hdl/lpddr_bank_defs.svh
// Purpose: constants for the bank command state tracker
// Assumes: 250 MHz sys_clk, 4 ns period
// Notes: times in ns, counts derived by rounding up
//
// Summary of operation
// - burst-terminate pattern with clock gate low enters deep sleep.
// - deep sleep drops array power; stored contents become invalid.
// - chip select high ignores strobes; operations in progress continue.
// - select low, other strobes high is a no-op; work continues.
// - activate pattern opens a row only in an idle bank.
// - open bank takes reads and writes, with or without autoprecharge.
// - precharge to a plain read truncates it and starts precharging.
// - precharge to a plain write truncates it; controller masks bytes.
// - burst terminate ends the latest registered read, any bank.
// - commands count only with clock gate high on two edges, after exits.
// - bank is activating until activate delay elapses, then row active.
// - autoprecharge access stays busy until precharge wait, then idle.
// - refresh lasts refresh cycle time, then all banks idle.
// - mode load lasts mode load delay, then all banks idle.
// - precharge all lasts precharge wait, then every bank idle.
// - bank idle only after precharge wait or at once on deep sleep entry; unlisted commands are illegal.
// - precharge with autoprecharge bit high hits all banks, else one bank.
`ifndef LPDDR_BANK_DEFS_SVH
`define LPDDR_BANK_DEFS_SVH
`define CLK_PERIOD_PS        4000
`define T_RP_NS              15
`define T_RCD_NS             15
`define T_RFC_NS             72
`define T_MRD_NS             10
`define T_XSR_NS             112
`define T_XP_NS              10
`define NS_TO_CYC(t)         \
  (((t) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_RP               `NS_TO_CYC(`T_RP_NS)
`define CYC_RCD              `NS_TO_CYC(`T_RCD_NS)
`define CYC_RFC              `NS_TO_CYC(`T_RFC_NS)
`define CYC_MRD              `NS_TO_CYC(`T_MRD_NS)
`define CYC_XSR              `NS_TO_CYC(`T_XSR_NS)
`define CYC_XP               `NS_TO_CYC(`T_XP_NS)
`define TIMER_W              8
`endif

// File: hdl/lpddr_bank_pkg.sv
// Purpose: types for the bank command state tracker
// Assumes: nothing
// Notes: command codes follow the strobe patterns {ras,cas,we}
`default_nettype none
package lpddr_bank_pkg;
  typedef enum logic [2:0] {
    CMD_MODE_LOAD = 3'h0,
    CMD_REFRESH   = 3'h1,
    CMD_PRECHARGE = 3'h2,
    CMD_ACTIVATE  = 3'h3,
    CMD_WRITE     = 3'h4,
    CMD_READ      = 3'h5,
    CMD_TERMINATE = 3'h6,
    CMD_NOP       = 3'h7
  } cmd_t;
  typedef enum logic [6:0] {
    BK_IDLE       = 7'h01,
    BK_ACTIVATING = 7'h02,
    BK_ACTIVE     = 7'h04,
    BK_READ       = 7'h08,
    BK_WRITE      = 7'h10,
    BK_AUTO_PRE   = 7'h20,
    BK_PRECHARGE  = 7'h40
  } bank_state_t;
  typedef enum logic [4:0] {
    DEV_NORMAL    = 5'h01,
    DEV_REFRESH   = 5'h02,
    DEV_MODE_LOAD = 5'h04,
    DEV_PRE_ALL   = 5'h08,
    DEV_SLEEP     = 5'h10
  } dev_state_t;
endpackage
`default_nettype wire

// File: hdl/lpddr_cmd_decode.sv
// Purpose: registers the strobes and decodes one command per edge
// Assumes: strobes synchronous to sys_clk
// Notes: one cycle of latency from pins to decoded command
`include "lpddr_bank_defs.svh"
`default_nettype none
module lpddr_cmd_decode
  import lpddr_bank_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       chip_select_n,
  input  wire logic       row_strobe_n,
  input  wire logic       col_strobe_n,
  input  wire logic       write_enable_n,
  input  wire logic       clock_gate,
  output var  cmd_t       cmd,
  output var  logic       gate_now,
  output var  logic       gate_prev
);
  cmd_t cmd_reg, cmd_next;
  logic gate_reg, gate_prev_reg;

  always_comb begin
    if (chip_select_n)
      cmd_next = CMD_NOP;
    else
      cmd_next = cmd_t'({row_strobe_n, col_strobe_n,
                         write_enable_n});
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg       <= CMD_NOP;
      gate_reg      <= 1'b0;
      gate_prev_reg <= 1'b0;
    end else begin
      cmd_reg       <= cmd_next;
      gate_reg      <= clock_gate;
      gate_prev_reg <= gate_reg;
    end
  end

  assign cmd       = cmd_reg;
  assign gate_now  = gate_reg;
  assign gate_prev = gate_prev_reg;

  property p_deselect_nop;
    @(posedge sys_clk) disable iff (!rst_n)
      chip_select_n |=> cmd == CMD_NOP;
  endproperty
  a_deselect_nop: assert property (p_deselect_nop)
    else $error("deselect did not decode as no-op");
endmodule
`default_nettype wire

// File: hdl/lpddr_bank_fsm.sv
// Purpose: one bank's state and countdown timer
// Assumes: commands already checked as legal by the top
// Notes: timer loads on entry to a timed state
`include "lpddr_bank_defs.svh"
`default_nettype none
module lpddr_bank_fsm
  import lpddr_bank_pkg::*;
#(
  parameter int TIMER_W = `TIMER_W
)(
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               do_activate,
  input  wire logic               do_read,
  input  wire logic               do_write,
  input  wire logic               auto_pre,
  input  wire logic               do_precharge,
  input  wire logic               do_end_read,
  input  wire logic               force_idle,
  input  wire logic [TIMER_W-1:0] rcd_cycles,
  input  wire logic [TIMER_W-1:0] rp_cycles,
  output var  bank_state_t        state
);
  bank_state_t state_reg, state_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic done;

  assign done = (timer_reg <= {{(TIMER_W-1){1'b0}}, 1'b1});

  always_comb begin
    state_next = state_reg;
    timer_next = (timer_reg != '0) ? timer_reg - 1'b1 : timer_reg;
    case (state_reg)
      BK_IDLE: if (do_activate) begin
        state_next = BK_ACTIVATING;
        timer_next = rcd_cycles;
      end
      BK_ACTIVATING: if (done)
        state_next = BK_ACTIVE;
      BK_ACTIVE, BK_READ, BK_WRITE: begin
        if (do_precharge) begin
          state_next = BK_PRECHARGE;
          timer_next = rp_cycles;
        end else if (do_read || do_write) begin
          timer_next = rp_cycles;
          if (auto_pre)
            state_next = BK_AUTO_PRE;
          else
            state_next = do_read ? BK_READ : BK_WRITE;
        end else if (do_end_read && state_reg == BK_READ)
          state_next = BK_ACTIVE;
      end
      BK_AUTO_PRE, BK_PRECHARGE: if (done)
        state_next = BK_IDLE;
      default: state_next = BK_IDLE;
    endcase
    if (force_idle) begin
      state_next = BK_IDLE;
      timer_next = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BK_IDLE;
      timer_reg <= '0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  assign state = state_reg;

  property p_activating_len;
    @(posedge sys_clk) disable iff (!rst_n)
      ($rose(state_reg == BK_ACTIVATING) && rcd_cycles == 8'h04 && !force_idle)
        |-> (state_reg == BK_ACTIVATING)[*4] ##1 state_reg == BK_ACTIVE;
  endproperty
  a_activating_len: assert property (p_activating_len)
    else $error("activating period wrong length");

  property p_precharge_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == BK_PRECHARGE && timer_reg == 8'h01)
        |=> state_reg == BK_IDLE;
  endproperty
  a_precharge_idle: assert property (p_precharge_idle)
    else $error("precharge did not end in idle");

  property p_auto_pre_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == BK_AUTO_PRE && timer_reg == 8'h01)
        |=> state_reg == BK_IDLE;
  endproperty
  a_auto_pre_idle: assert property (p_auto_pre_idle)
    else $error("auto precharge did not end in idle");
endmodule
`default_nettype wire

// File: hdl/lpddr_bank_command_state.sv
// Purpose: per-bank command acceptance and device-wide states
// Assumes: controller obeys the partner-side command ordering
// Notes: illegal commands are flagged and otherwise ignored
`include "lpddr_bank_defs.svh"
`default_nettype none
module lpddr_bank_command_state
  import lpddr_bank_pkg::*;
#(
  parameter int NUM_BANKS = 4,
  parameter int BANK_W    = 2,
  parameter int TIMER_W   = `TIMER_W
)(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  chip_select_n,
  input  wire logic                  row_strobe_n,
  input  wire logic                  col_strobe_n,
  input  wire logic                  write_enable_n,
  input  wire logic                  clock_gate,
  input  wire logic [BANK_W-1:0]     bank_select,
  input  wire logic                  autoprecharge_bit,
  input  wire logic                  init_done,
  output logic [NUM_BANKS-1:0]       bank_idle,
  output logic [NUM_BANKS-1:0]       bank_open,
  output logic                       all_idle,
  output logic                       deep_sleep,
  output logic                       contents_valid,
  output logic                       device_busy,
  output logic                       illegal_cmd
);
  if (NUM_BANKS != (1 << BANK_W) || TIMER_W < 8) begin : g_bad_param
    $error("bank count or timer width not supported");
  end

  localparam logic [TIMER_W-1:0] RCD_C = TIMER_W'(`CYC_RCD);
  localparam logic [TIMER_W-1:0] RP_C  = TIMER_W'(`CYC_RP);
  localparam logic [TIMER_W-1:0] RFC_C = TIMER_W'(`CYC_RFC);
  localparam logic [TIMER_W-1:0] MRD_C = TIMER_W'(`CYC_MRD);

  cmd_t cmd;
  logic gate_now, gate_prev;
  logic [BANK_W-1:0] bank_d_reg;
  logic              ap_d_reg;

  lpddr_cmd_decode u_dec (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .chip_select_n  (chip_select_n),
    .row_strobe_n   (row_strobe_n),
    .col_strobe_n   (col_strobe_n),
    .write_enable_n (write_enable_n),
    .clock_gate     (clock_gate),
    .cmd            (cmd),
    .gate_now       (gate_now),
    .gate_prev      (gate_prev)
  );

  // address bits aligned with the decoded command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_d_reg <= '0;
      ap_d_reg   <= 1'b0;
    end else begin
      bank_d_reg <= bank_select;
      ap_d_reg   <= autoprecharge_bit;
    end
  end

  dev_state_t dev_reg, dev_next;
  logic [TIMER_W-1:0] dtimer_reg, dtimer_next;
  logic valid_reg, valid_next;
  logic [BANK_W-1:0] last_rd_reg, last_rd_next;
  logic illegal_reg, illegal_next;
  bank_state_t st [NUM_BANKS];
  logic [NUM_BANKS-1:0] idle_v, read_v, pre_ok_v, act_v;
  logic cmd_ok, ok_all_idle, dtimer_done;
  logic acc_ok, term_ok, pre_ok, act_ok, is_pre_all;

  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      idle_v[i]   = (st[i] == BK_IDLE);
      read_v[i]   = (st[i] == BK_READ);
      act_v[i]    = (st[i] == BK_ACTIVE) || (st[i] == BK_READ)
                    || (st[i] == BK_WRITE);
      pre_ok_v[i] = act_v[i] || idle_v[i];
    end
  end

  // commands count only with clock gate held high and device usable
  assign cmd_ok = gate_now && gate_prev && valid_reg
                  && dev_reg == DEV_NORMAL;
  assign ok_all_idle = &idle_v;
  assign dtimer_done = (dtimer_reg <= {{(TIMER_W-1){1'b0}}, 1'b1});
  assign is_pre_all  = (cmd == CMD_PRECHARGE) && ap_d_reg;
  assign act_ok  = idle_v[bank_d_reg];
  assign acc_ok  = act_v[bank_d_reg];
  assign term_ok = read_v[last_rd_reg];
  assign pre_ok  = is_pre_all ? &pre_ok_v : pre_ok_v[bank_d_reg];

  logic [NUM_BANKS-1:0] b_act, b_rd, b_wr, b_pre, b_end;
  logic                 b_force;

  always_comb begin
    dev_next     = dev_reg;
    dtimer_next  = (dtimer_reg != '0) ? dtimer_reg - 1'b1 : dtimer_reg;
    valid_next   = valid_reg;
    last_rd_next = last_rd_reg;
    illegal_next = 1'b0;
    b_act = '0;
    b_rd  = '0;
    b_wr  = '0;
    b_pre = '0;
    b_end = '0;
    b_force = 1'b0;
    case (dev_reg)
      DEV_NORMAL: begin
        if (!valid_reg && init_done)
          valid_next = 1'b1;
        if (gate_prev && !gate_now && cmd == CMD_TERMINATE
            && valid_reg) begin
          dev_next   = DEV_SLEEP;
          valid_next = 1'b0;
          b_force    = 1'b1;
        end else if (cmd_ok) begin
          case (cmd)
            CMD_NOP: ;
            CMD_ACTIVATE:
              if (act_ok) b_act[bank_d_reg] = 1'b1;
              else illegal_next = 1'b1;
            CMD_READ, CMD_WRITE:
              if (acc_ok) begin
                if (cmd == CMD_READ) begin
                  b_rd[bank_d_reg] = 1'b1;
                  last_rd_next = bank_d_reg;
                end else
                  b_wr[bank_d_reg] = 1'b1;
              end else illegal_next = 1'b1;
            CMD_TERMINATE:
              if (term_ok) b_end[last_rd_reg] = 1'b1;
              else illegal_next = 1'b1;
            CMD_PRECHARGE:
              if (!pre_ok) illegal_next = 1'b1;
              else if (is_pre_all) begin
                for (int i = 0; i < NUM_BANKS; i++)
                  b_pre[i] = act_v[i];
                dev_next    = DEV_PRE_ALL;
                dtimer_next = RP_C;
              end else
                b_pre[bank_d_reg] = act_v[bank_d_reg];
            CMD_REFRESH:
              if (ok_all_idle) begin
                dev_next    = DEV_REFRESH;
                dtimer_next = RFC_C;
              end else illegal_next = 1'b1;
            CMD_MODE_LOAD:
              if (ok_all_idle) begin
                dev_next    = DEV_MODE_LOAD;
                dtimer_next = MRD_C;
              end else illegal_next = 1'b1;
            default: illegal_next = 1'b1;
          endcase
        end
      end
      DEV_REFRESH, DEV_MODE_LOAD, DEV_PRE_ALL: begin
        if (gate_now && cmd != CMD_NOP)
          illegal_next = 1'b1;
        if (dtimer_done) begin
          dev_next = DEV_NORMAL;
          b_force  = 1'b1;
        end
      end
      DEV_SLEEP: begin
        b_force = 1'b1;
        if (gate_now)
          dev_next = DEV_NORMAL;
      end
      default: dev_next = DEV_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_reg     <= DEV_NORMAL;
      dtimer_reg  <= '0;
      valid_reg   <= 1'b0;
      last_rd_reg <= '0;
      illegal_reg <= 1'b0;
    end else begin
      dev_reg     <= dev_next;
      dtimer_reg  <= dtimer_next;
      valid_reg   <= valid_next;
      last_rd_reg <= last_rd_next;
      illegal_reg <= illegal_next;
    end
  end

  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    lpddr_bank_fsm #(.TIMER_W(TIMER_W)) u_bank (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .do_activate  (b_act[g]),
      .do_read      (b_rd[g]),
      .do_write     (b_wr[g]),
      .auto_pre     (ap_d_reg),
      .do_precharge (b_pre[g]),
      .do_end_read  (b_end[g]),
      .force_idle   (b_force),
      .rcd_cycles   (RCD_C),
      .rp_cycles    (RP_C),
      .state        (st[g])
    );
  end

  logic [NUM_BANKS-1:0] idle_o_reg, open_o_reg;
  logic all_idle_o_reg, sleep_o_reg, busy_o_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_o_reg     <= '0;
      open_o_reg     <= '0;
      all_idle_o_reg <= 1'b0;
      sleep_o_reg    <= 1'b0;
      busy_o_reg     <= 1'b0;
    end else begin
      idle_o_reg     <= idle_v;
      open_o_reg     <= act_v;
      all_idle_o_reg <= ok_all_idle && dev_reg == DEV_NORMAL;
      sleep_o_reg    <= (dev_next == DEV_SLEEP);
      busy_o_reg     <= (dev_next != DEV_NORMAL)
                        && (dev_next != DEV_SLEEP);
    end
  end

  assign bank_idle      = idle_o_reg;
  assign bank_open      = open_o_reg;
  assign all_idle       = all_idle_o_reg;
  assign deep_sleep     = sleep_o_reg;
  assign contents_valid = valid_reg;
  assign device_busy    = busy_o_reg;
  assign illegal_cmd    = illegal_reg;

  property p_sleep_entry;
    @(posedge sys_clk) disable iff (!rst_n)
      (dev_reg == DEV_NORMAL && valid_reg && gate_prev && !gate_now
       && cmd == CMD_TERMINATE) |=> deep_sleep && !contents_valid;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("deep sleep not entered");

  property p_sleep_loses;
    @(posedge sys_clk) disable iff (!rst_n)
      dev_reg == DEV_SLEEP |-> !valid_reg;
  endproperty
  a_sleep_loses: assert property (p_sleep_loses)
    else $error("contents valid during deep sleep");

  property p_refresh_len;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(dev_reg == DEV_REFRESH) |-> (dev_reg == DEV_REFRESH)[*8]
        ##[10:11] dev_reg == DEV_NORMAL && ok_all_idle;
  endproperty
  a_refresh_len: assert property (p_refresh_len)
    else $error("refresh period wrong");

  property p_mode_len;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(dev_reg == DEV_MODE_LOAD) |-> (dev_reg == DEV_MODE_LOAD)[*3]
        ##1 dev_reg == DEV_NORMAL;
  endproperty
  a_mode_len: assert property (p_mode_len)
    else $error("mode load period wrong");

  property p_pre_all;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(dev_reg == DEV_PRE_ALL) |-> (dev_reg == DEV_PRE_ALL)[*4]
        ##1 (dev_reg == DEV_NORMAL) ##1 ok_all_idle;
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("precharge all did not leave banks idle");

  property p_gate_needed;
    @(posedge sys_clk) disable iff (!rst_n)
      (!gate_prev && dev_reg == DEV_NORMAL) |=> $stable(idle_v);
  endproperty
  a_gate_needed: assert property (p_gate_needed)
    else $error("command taken with clock gate low");
endmodule
`default_nettype wire

// File: bench/lpddr_ctrl_model.sv
// Purpose: controller side that issues strobe commands
// Assumes: commands launched 1 ns after sys_clk rises
// Notes: callers order commands; address lines scramble when unused
`default_nettype none
module lpddr_ctrl_model
  import lpddr_bank_pkg::*;
(
  input  wire logic       sys_clk,
  output var  logic       chip_select_n,
  output var  logic       row_strobe_n,
  output var  logic       col_strobe_n,
  output var  logic       write_enable_n,
  output var  logic       clock_gate,
  output var  logic [1:0] bank_select,
  output var  logic       autoprecharge_bit
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    chip_select_n = 1'b1;
    {row_strobe_n, col_strobe_n, write_enable_n} = CMD_NOP;
    clock_gate = 1'b1;
    bank_select = 2'h0;
    autoprecharge_bit = 1'b0;
  end
  // refresh/mode only when idle, precharge valid banks
  // no data beats are driven, so no bytes need masking
  // no write into a live read, terminate only plain reads
  task automatic send(input cmd_t c, input logic [1:0] b, input logic ap,
                      input logic g, input logic cs_n);
    @(posedge sys_clk);
    #1;
    chip_select_n = cs_n;
    {row_strobe_n, col_strobe_n, write_enable_n} = c;
    bank_select = b;
    autoprecharge_bit = ap;
    clock_gate = g;
    @(posedge sys_clk);
    #1;
    chip_select_n = 1'b0;
    {row_strobe_n, col_strobe_n, write_enable_n} = CMD_NOP;
    bank_select = ~b;
    autoprecharge_bit = ~ap;
  endtask
  task automatic set_gate(input logic g);
    @(posedge sys_clk);
    #1;
    clock_gate = g;
  endtask
endmodule
`default_nettype wire

// File: bench/test_lpddr_bank_command_state.sv
// Purpose: self-checking bench for the bank command tracker
// Assumes: 250 MHz sys_clk, async active-low reset
// Notes: state outputs are sampled 1 ns after an edge
`include "lpddr_bank_defs.svh"
`default_nettype none
module test_lpddr_bank_command_state
  import lpddr_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk, rst_n, init_done;
  logic       cs_n, ras_n, cas_n, we_n, gate, ap;
  logic [1:0] bsel;
  logic [3:0] bank_idle, bank_open;
  logic       all_idle, deep_sleep, contents_valid, device_busy, illegal_cmd;
  int         n_fail, tests_run, n_ill, i0;

  lpddr_ctrl_model ctl (.sys_clk(sys_clk), .chip_select_n(cs_n),
    .row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_enable_n(we_n),
    .clock_gate(gate), .bank_select(bsel), .autoprecharge_bit(ap));
  lpddr_bank_command_state DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .chip_select_n(cs_n), .row_strobe_n(ras_n), .col_strobe_n(cas_n),
    .write_enable_n(we_n), .clock_gate(gate), .bank_select(bsel),
    .autoprecharge_bit(ap), .init_done(init_done), .bank_idle(bank_idle),
    .bank_open(bank_open), .all_idle(all_idle), .deep_sleep(deep_sleep),
    .contents_valid(contents_valid), .device_busy(device_busy),
    .illegal_cmd(illegal_cmd));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (illegal_cmd === 1'b1) n_ill++;

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [3:0] e,
                     input logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic t_reset;
    idle(2);
    chk("valid", 4'h0, {3'h0, contents_valid});
    chk("idle", 4'hF, bank_idle);
    ctl.send(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1, 1'b0);
    idle(3);
    chk("pre-init idle", 4'hF, bank_idle);
    init_done = 1'b1;
    idle(3);
    chk("valid", 4'h1, {3'h0, contents_valid});
    chk("all idle", 4'h1, {3'h0, all_idle});
    chk("illegal", 4'h0, 4'(n_ill));
    $display("done reset");
  endtask
  task automatic t_act;
    i0 = n_ill;
    ctl.send(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1, 1'b0);
    idle(2);
    chk("activating", 4'hE, bank_idle);
    chk("not open", 4'h0, bank_open);
    idle(8);
    chk("open", 4'h1, bank_open);
    ctl.send(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1, 1'b0);
    ctl.send(CMD_READ, 2'h2, 1'b0, 1'b1, 1'b0);
    idle(3);
    chk("refused", 4'h2, 4'(n_ill - i0));
    chk("open", 4'h1, bank_open);
    $display("done activate");
  endtask
  task automatic t_rd;
    i0 = n_ill;
    ctl.send(CMD_READ, 2'h0, 1'b0, 1'b1, 1'b0);
    ctl.send(CMD_TERMINATE, 2'h3, 1'b0, 1'b1, 1'b0);
    idle(3);
    chk("term open", 4'h1, bank_open);
    ctl.send(CMD_READ, 2'h0, 1'b0, 1'b1, 1'b0);
    ctl.send(CMD_PRECHARGE, 2'h0, 1'b0, 1'b1, 1'b0);
    idle(2);
    chk("trunc open", 4'h0, bank_open);
    chk("trunc idle", 4'hE, bank_idle);
    idle(8);
    chk("pre idle", 4'hF, bank_idle);
    chk("no refusal", 4'h0, 4'(n_ill - i0));
    $display("done read");
  endtask
  task automatic t_ap;
    i0 = n_ill;
    ctl.send(CMD_ACTIVATE, 2'h1, 1'b0, 1'b1, 1'b0);
    idle(8);
    ctl.send(CMD_WRITE, 2'h1, 1'b0, 1'b1, 1'b0);
    ctl.send(CMD_PRECHARGE, 2'h1, 1'b0, 1'b1, 1'b0);
    idle(2);
    chk("wr trunc", 4'h0, bank_open);
    idle(8);
    chk("wr idle", 4'hF, bank_idle);
    chk("wr legal", 4'h0, 4'(n_ill - i0));
    ctl.send(CMD_ACTIVATE, 2'h1, 1'b0, 1'b1, 1'b0);
    idle(8);
    ctl.send(CMD_WRITE, 2'h1, 1'b1, 1'b1, 1'b0);
    idle(2);
    chk("ap busy", 4'hD, bank_idle);
    idle(10);
    chk("ap idle", 4'hF, bank_idle);
    chk("ap open", 4'h0, bank_open);
    $display("done autoprecharge");
  endtask
  task automatic t_sel;
    i0 = n_ill;
    ctl.send(CMD_ACTIVATE, 2'h3, 1'b0, 1'b1, 1'b1);
    idle(3);
    chk("deselect", 4'hF, bank_idle);
    ctl.set_gate(1'b0);
    ctl.send(CMD_ACTIVATE, 2'h3, 1'b0, 1'b1, 1'b0);
    idle(3);
    chk("gate edge", 4'hF, bank_idle);
    chk("silent", 4'h0, 4'(n_ill - i0));
    $display("done deselect");
  endtask
  task automatic t_ref;
    ctl.send(CMD_REFRESH, 2'h0, 1'b0, 1'b1, 1'b0);
    idle(2);
    chk("ref busy", 4'h1, {3'h0, device_busy});
    idle(`CYC_RFC - 4);
    chk("ref still", 4'h1, {3'h0, device_busy});
    idle(8);
    chk("ref done", 4'h1, {2'h0, device_busy, all_idle});
    ctl.send(CMD_MODE_LOAD, 2'h0, 1'b0, 1'b1, 1'b0);
    idle(2);
    chk("mode busy", 4'h1, {3'h0, device_busy});
    idle(6);
    chk("mode done", 4'h1, {2'h0, device_busy, all_idle});
    $display("done refresh");
  endtask
  task automatic t_pre;
    ctl.send(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1, 1'b0);
    ctl.send(CMD_ACTIVATE, 2'h2, 1'b0, 1'b1, 1'b0);
    idle(8);
    chk("two open", 4'h5, bank_open);
    ctl.send(CMD_PRECHARGE, 2'h2, 1'b0, 1'b1, 1'b0);
    idle(8);
    chk("one pre", 4'h1, bank_open);
    ctl.send(CMD_ACTIVATE, 2'h2, 1'b0, 1'b1, 1'b0);
    idle(8);
    ctl.send(CMD_PRECHARGE, 2'h1, 1'b1, 1'b1, 1'b0);
    idle(2);
    chk("all busy", 4'h1, {3'h0, device_busy});
    idle(8);
    chk("all idle", 4'hF, bank_idle);
    chk("all done", 4'h1, {2'h0, device_busy, all_idle});
    $display("done precharge");
  endtask
  task automatic t_sleep;
    init_done = 1'b0;
    ctl.send(CMD_TERMINATE, 2'h0, 1'b0, 1'b0, 1'b0);
    idle(2);
    chk("sleep", 4'h1, {3'h0, deep_sleep});
    chk("lost", 4'h0, {3'h0, contents_valid});
    ctl.set_gate(1'b1);
    idle(3);
    chk("woke", 4'h0, {2'h0, deep_sleep, contents_valid});
    init_done = 1'b1;
    idle(3);
    chk("reinit", 4'h1, {3'h0, contents_valid});
    $display("done sleep");
  endtask

  initial begin
    n_fail = 0;
    tests_run = 0;
    n_ill = 0;
    rst_n = 1'b0;
    init_done = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_act();
    t_rd();
    t_ap();
    t_sel();
    t_ref();
    t_pre();
    t_sleep();
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule
`default_nettype wire
